/* File: hpdc_pkg.sv */
package hpdc_pkg;
  // Byte offsets on the configuration port
  localparam logic [7:0] OFS_MAX_POWER_SELF = 8'h0c;
  localparam logic [7:0] OFS_MAX_POWER_BUS = 8'h0d;
  localparam logic [7:0] OFS_CTRL_CURRENT_SELF = 8'h0e;
  localparam logic [7:0] OFS_CTRL_CURRENT_BUS = 8'h0f;
  localparam logic [7:0] OFS_SETTLE_TIME = 8'h10;
  localparam logic [7:0] OFS_LANG_UPPER = 8'h11;
  localparam logic [7:0] OFS_LANG_LOWER = 8'h12;
  localparam logic [7:0] OFS_MAKER_LEN = 8'h13;
  localparam logic [7:0] OFS_MAKER_STR_FIRST = 8'h16;
  localparam logic [7:0] OFS_MAKER_STR_LAST = 8'h53;

  // Values after reset
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_CTRL_CURRENT = 8'h32;

  // Units and limits
  localparam int MA_PER_UNIT = 2;
  localparam logic [7:0] SELF_LIMIT_UNITS = 8'h32;
  localparam logic [7:0] STR_MAX_CHARS = 8'h1f;
  localparam int STR_BYTES = 62;

  // Settle timer step: 2 ms at 25 MHz
  localparam int SETTLE_STEP_MS = 2;
  localparam int CLK_KHZ = 25_000;
  localparam int SETTLE_STEP_CYCLES = SETTLE_STEP_MS * CLK_KHZ;
endpackage

/* File: hpdc_settle_timer.sv */
`timescale 1ns/1ps
`default_nettype none

module hpdc_settle_timer #(
  parameter int STEP_CYCLES = hpdc_pkg::SETTLE_STEP_CYCLES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic start,
  input wire logic [7:0] steps,
  output logic power_good
);
  localparam logic [15:0] STEP_LAST = 16'(STEP_CYCLES - 1);

  // Elaboration check; the sub-counter is sixteen bits wide
  if (STEP_CYCLES < 1 || STEP_CYCLES > 65536) begin : g_bad_step
    $error("hpdc_settle_timer: STEP_CYCLES out of range");
  end

  logic [7:0] step_reg;
  logic [7:0] step_next;
  logic [15:0] sub_reg;
  logic [15:0] sub_next;
  logic good_next;

  // Counts steps of STEP_CYCLES; a new start restarts the wait
  always_comb begin
    step_next = step_reg;
    sub_next = sub_reg;
    good_next = power_good;
    if (start) begin
      step_next = steps;
      sub_next = STEP_LAST;
      good_next = (steps == 8'h00);
    end else if (step_reg != 8'h00) begin
      if (sub_reg == 16'h0000) begin
        sub_next = STEP_LAST;
        step_next = step_reg - 8'h01;
        good_next = (step_reg == 8'h01);
      end else begin
        sub_next = sub_reg - 16'h0001;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      step_reg <= 8'h00;
      sub_reg <= 16'h0000;
      power_good <= 1'b0;
    end else if (ce) begin
      step_reg <= step_next;
      sub_reg <= sub_next;
      power_good <= good_next;
    end
  end
endmodule // hpdc_settle_timer

`default_nettype wire

/* File: hpdc_config.sv */
// Contract
// - Self-powered max power byte counts upstream draw in 2 mA units.
// - Bus-powered max power byte counts upstream draw in 2 mA units.
// - Self-powered controller current byte, 2 mA units, excludes embedded peripheral.
// - Bus-powered controller current byte, 2 mA units, excludes embedded peripheral.
// - Both controller current bytes reset to 50, meaning 100 mA.
// - Settle time byte counts 2 ms steps from power-on start to stable.
// - Language identifier is upper byte and lower byte of sixteen bits.
// - Maker string length counts characters and never exceeds 31.
// - Each maker character is two bytes, low byte at lower address.
`timescale 1ns/1ps
`default_nettype none

module hpdc_config #(
  parameter int SETTLE_STEP_CYCLES = hpdc_pkg::SETTLE_STEP_CYCLES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [7:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  output logic [7:0] cfg_rdata,
  output logic cfg_rvalid,
  input wire logic self_powered_pin,
  input wire logic port_power_start,
  output logic port_power_good,
  output logic [7:0] rpt_max_power,
  output logic [7:0] rpt_ctrl_current,
  output logic [8:0] rpt_max_power_ma,
  output logic [8:0] rpt_ctrl_current_ma,
  output logic rpt_self_powered,
  output logic [15:0] rpt_language_id,
  output logic [7:0] rpt_maker_len,
  input wire logic [4:0] str_char_idx,
  output logic [15:0] str_char,
  output logic self_limit_exceeded
);
  // Elaboration checks; the timer's sub-counter is sixteen bits wide
  if (SETTLE_STEP_CYCLES < 1 || SETTLE_STEP_CYCLES > 65536) begin : g_bad_step
    $error("hpdc_config: SETTLE_STEP_CYCLES out of range");
  end

  // String window must span exactly the byte store
  if (int'(hpdc_pkg::OFS_MAKER_STR_LAST) - int'(hpdc_pkg::OFS_MAKER_STR_FIRST) + 1 !=
      hpdc_pkg::STR_BYTES) begin : g_bad_window
    $error("hpdc_config: string window does not match the byte store");
  end

  // Two bytes per character, and a six-bit byte index
  if (hpdc_pkg::STR_BYTES != 2 * int'(hpdc_pkg::STR_MAX_CHARS) ||
      hpdc_pkg::STR_BYTES > 64) begin : g_bad_store
    $error("hpdc_config: byte store does not fit the character limit");
  end

  // The string window must sit above every register offset
  if (hpdc_pkg::OFS_MAKER_STR_FIRST <= hpdc_pkg::OFS_MAKER_LEN) begin : g_bad_order
    $error("hpdc_config: string window overlaps the registers");
  end

  // Configuration bytes
  logic [7:0] max_power_self_reg;
  logic [7:0] max_power_self_next;
  logic [7:0] max_power_bus_reg;
  logic [7:0] max_power_bus_next;
  logic [7:0] controller_current_self_reg;
  logic [7:0] controller_current_self_next;
  logic [7:0] controller_current_bus_reg;
  logic [7:0] controller_current_bus_next;
  logic [7:0] port_power_settle_time_reg;
  logic [7:0] port_power_settle_time_next;
  logic [7:0] language_id_upper_reg;
  logic [7:0] language_id_upper_next;
  logic [7:0] language_id_lower_reg;
  logic [7:0] language_id_lower_next;
  logic [7:0] maker_string_length_reg;
  logic [7:0] maker_string_length_next;

  // Manufacturer string bytes, low byte of each character first
  logic [7:0] maker_string_chars [hpdc_pkg::STR_BYTES];
  logic str_wr;
  logic [5:0] str_wr_idx;

  // Read side and pin synchroniser
  logic [7:0] rdata_next;
  logic rvalid_next;
  logic sp_meta_reg;
  logic sp_sync_reg;

  // Power report group
  logic [7:0] rpt_max_power_next;
  logic [7:0] rpt_ctrl_current_next;
  logic [8:0] rpt_max_power_ma_next;
  logic [8:0] rpt_ctrl_current_ma_next;
  logic limit_next;

  // Descriptor report group
  logic [15:0] rpt_language_id_next;
  logic [15:0] str_char_next;
  logic [5:0] char_lo_idx;
  logic [5:0] char_hi_idx;
  logic char_in_range;
  logic [7:0] str_offset;

  // Register writes; an oversize string length is clamped rather than refused
  always_comb begin
    max_power_self_next = max_power_self_reg;
    max_power_bus_next = max_power_bus_reg;
    controller_current_self_next = controller_current_self_reg;
    controller_current_bus_next = controller_current_bus_reg;
    port_power_settle_time_next = port_power_settle_time_reg;
    language_id_upper_next = language_id_upper_reg;
    language_id_lower_next = language_id_lower_reg;
    maker_string_length_next = maker_string_length_reg;
    if (cfg_wr) begin
      unique case (cfg_addr)
        hpdc_pkg::OFS_MAX_POWER_SELF: max_power_self_next = cfg_wdata;
        hpdc_pkg::OFS_MAX_POWER_BUS: max_power_bus_next = cfg_wdata;
        hpdc_pkg::OFS_CTRL_CURRENT_SELF: controller_current_self_next = cfg_wdata;
        hpdc_pkg::OFS_CTRL_CURRENT_BUS: controller_current_bus_next = cfg_wdata;
        hpdc_pkg::OFS_SETTLE_TIME: port_power_settle_time_next = cfg_wdata;
        hpdc_pkg::OFS_LANG_UPPER: language_id_upper_next = cfg_wdata;
        hpdc_pkg::OFS_LANG_LOWER: language_id_lower_next = cfg_wdata;
        hpdc_pkg::OFS_MAKER_LEN: begin
          maker_string_length_next = (cfg_wdata > hpdc_pkg::STR_MAX_CHARS) ?
            hpdc_pkg::STR_MAX_CHARS : cfg_wdata;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      max_power_self_reg <= hpdc_pkg::RST_ZERO;
      max_power_bus_reg <= hpdc_pkg::RST_ZERO;
      controller_current_self_reg <= hpdc_pkg::RST_CTRL_CURRENT;
      controller_current_bus_reg <= hpdc_pkg::RST_CTRL_CURRENT;
      port_power_settle_time_reg <= hpdc_pkg::RST_ZERO;
      language_id_upper_reg <= hpdc_pkg::RST_ZERO;
      language_id_lower_reg <= hpdc_pkg::RST_ZERO;
      maker_string_length_reg <= hpdc_pkg::RST_ZERO;
    end else if (ce) begin
      max_power_self_reg <= max_power_self_next;
      max_power_bus_reg <= max_power_bus_next;
      controller_current_self_reg <= controller_current_self_next;
      controller_current_bus_reg <= controller_current_bus_next;
      port_power_settle_time_reg <= port_power_settle_time_next;
      language_id_upper_reg <= language_id_upper_next;
      language_id_lower_reg <= language_id_lower_next;
      maker_string_length_reg <= maker_string_length_next;
    end
  end

  // String byte write decode
  always_comb begin
    str_offset = cfg_addr - hpdc_pkg::OFS_MAKER_STR_FIRST;
    str_wr = cfg_wr && (cfg_addr >= hpdc_pkg::OFS_MAKER_STR_FIRST) &&
      (cfg_addr <= hpdc_pkg::OFS_MAKER_STR_LAST);
    str_wr_idx = str_offset[5:0];
  end

  // String storage is cleared at reset so unwritten characters read as zero
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < hpdc_pkg::STR_BYTES; i++) begin
        maker_string_chars[i] <= hpdc_pkg::RST_ZERO;
      end
    end else if (ce && str_wr) begin
      maker_string_chars[str_wr_idx] <= cfg_wdata;
    end
  end

  // Read mux; unmapped offsets answer zero
  always_comb begin
    rvalid_next = cfg_rd;
    rdata_next = 8'h00;
    if (cfg_rd) begin
      unique case (cfg_addr)
        hpdc_pkg::OFS_MAX_POWER_SELF: rdata_next = max_power_self_reg;
        hpdc_pkg::OFS_MAX_POWER_BUS: rdata_next = max_power_bus_reg;
        hpdc_pkg::OFS_CTRL_CURRENT_SELF: rdata_next = controller_current_self_reg;
        hpdc_pkg::OFS_CTRL_CURRENT_BUS: rdata_next = controller_current_bus_reg;
        hpdc_pkg::OFS_SETTLE_TIME: rdata_next = port_power_settle_time_reg;
        hpdc_pkg::OFS_LANG_UPPER: rdata_next = language_id_upper_reg;
        hpdc_pkg::OFS_LANG_LOWER: rdata_next = language_id_lower_reg;
        hpdc_pkg::OFS_MAKER_LEN: rdata_next = maker_string_length_reg;
        default: begin
          if (cfg_addr >= hpdc_pkg::OFS_MAKER_STR_FIRST &&
              cfg_addr <= hpdc_pkg::OFS_MAKER_STR_LAST) begin
            rdata_next = maker_string_chars[str_offset[5:0]];
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfg_rdata <= 8'h00;
      cfg_rvalid <= 1'b0;
    end else if (ce) begin
      cfg_rdata <= rdata_next;
      cfg_rvalid <= rvalid_next;
    end
  end

  // Powering-mode pin crosses in from the board; two flops before use
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sp_meta_reg <= 1'b0;
      sp_sync_reg <= 1'b0;
    end else if (ce) begin
      sp_meta_reg <= self_powered_pin;
      sp_sync_reg <= sp_meta_reg;
    end
  end

  // Reported power figures; selection follows the synchronised mode each cycle
  always_comb begin
    rpt_max_power_next = sp_sync_reg ? max_power_self_reg : max_power_bus_reg;
    rpt_ctrl_current_next = sp_sync_reg ? controller_current_self_reg :
      controller_current_bus_reg;
    rpt_max_power_ma_next = 9'(rpt_max_power_next * hpdc_pkg::MA_PER_UNIT);
    rpt_ctrl_current_ma_next =
      9'(rpt_ctrl_current_next * hpdc_pkg::MA_PER_UNIT);
    // Flags a configurer that broke the self-powered ceiling; values still pass
    limit_next = (controller_current_self_reg > hpdc_pkg::SELF_LIMIT_UNITS) ||
      (max_power_self_reg > hpdc_pkg::SELF_LIMIT_UNITS);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rpt_max_power <= 8'h00;
      rpt_ctrl_current <= 8'h00;
      rpt_max_power_ma <= 9'h000;
      rpt_ctrl_current_ma <= 9'h000;
      rpt_self_powered <= 1'b0;
      self_limit_exceeded <= 1'b0;
    end else if (ce) begin
      rpt_max_power <= rpt_max_power_next;
      rpt_ctrl_current <= rpt_ctrl_current_next;
      rpt_max_power_ma <= rpt_max_power_ma_next;
      rpt_ctrl_current_ma <= rpt_ctrl_current_ma_next;
      rpt_self_powered <= sp_sync_reg;
      self_limit_exceeded <= limit_next;
    end
  end

  // Descriptor words; the byte index is range-checked before the store is read
  always_comb begin
    rpt_language_id_next = {language_id_upper_reg, language_id_lower_reg};
    char_lo_idx = {str_char_idx, 1'b0};
    char_hi_idx = {str_char_idx, 1'b1};
    // Characters past the stored length read as zero; index 31 would overrun the store
    char_in_range = ({3'b000, str_char_idx} < maker_string_length_reg) &&
      ({1'b0, char_hi_idx} < 7'(hpdc_pkg::STR_BYTES));
    str_char_next = 16'h0000;
    if (char_in_range) begin
      str_char_next = {maker_string_chars[char_hi_idx],
        maker_string_chars[char_lo_idx]};
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rpt_language_id <= 16'h0000;
      rpt_maker_len <= 8'h00;
      str_char <= 16'h0000;
    end else if (ce) begin
      rpt_language_id <= rpt_language_id_next;
      rpt_maker_len <= maker_string_length_reg;
      str_char <= str_char_next;
    end
  end

  // Port power settle wait in 2 ms steps
  hpdc_settle_timer #(
    .STEP_CYCLES(SETTLE_STEP_CYCLES)
  ) u_settle (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .start(port_power_start),
    .steps(port_power_settle_time_reg),
    .power_good(port_power_good)
  );
endmodule // hpdc_config

`default_nettype wire

/* File: hpdc_config_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module hpdc_config_sva (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [7:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic cfg_rvalid,
  input wire logic self_powered_pin,
  input wire logic port_power_start,
  input wire logic port_power_good,
  input wire logic [7:0] rpt_max_power,
  input wire logic [7:0] rpt_ctrl_current,
  input wire logic [8:0] rpt_max_power_ma,
  input wire logic [8:0] rpt_ctrl_current_ma,
  input wire logic rpt_self_powered,
  input wire logic [15:0] rpt_language_id,
  input wire logic [7:0] rpt_maker_len
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  // Read answers come one cycle after the strobe and never unasked
  a_rd_answer: assert property (ce && cfg_rd |=> cfg_rvalid) else $error("read unanswered");
  a_rvalid_cause: assert property (cfg_rvalid |-> $past(cfg_rd)) else $error("stray rvalid");
  // Milliamp outputs are the selected byte in 2 mA units
  a_power_ma: assert property (rpt_max_power_ma == {rpt_max_power, 1'h0})
    else $error("power mA wrong");
  a_current_ma: assert property (rpt_ctrl_current_ma == {rpt_ctrl_current, 1'h0})
    else $error("current mA wrong");
  // A byte written to either half shows in the identifier two edges later
  a_lang_upper: assert property (cfg_wr && cfg_addr == hpdc_pkg::OFS_LANG_UPPER |->
    ##2 rpt_language_id[15:8] == $past(cfg_wdata, 2)) else $error("id upper wrong");
  a_lang_lower: assert property (cfg_wr && cfg_addr == hpdc_pkg::OFS_LANG_LOWER |->
    ##2 rpt_language_id[7:0] == $past(cfg_wdata, 2)) else $error("id lower wrong");
  a_len_cap: assert property (rpt_maker_len <= hpdc_pkg::STR_MAX_CHARS)
    else $error("length above limit");
  // Three edges of sync and report latency, so four stable samples suffice
  a_mode_follow: assert property ($stable(self_powered_pin) [*4] |->
    rpt_self_powered == self_powered_pin) else $error("mode not followed");
  a_good_holds: assert property (port_power_good && !port_power_start |=> port_power_good)
    else $error("power good dropped");
  c_read: cover property (cfg_rvalid);
  c_good: cover property ($rose(port_power_good));
  c_self: cover property ($rose(rpt_self_powered));
endmodule // hpdc_config_sva
`default_nettype wire

/* File: hpdc_cfg_host.sv */
`timescale 1ns/1ps
`default_nettype none
module hpdc_cfg_host (
  input wire logic clk,
  output logic [7:0] cfg_addr,
  output logic [7:0] cfg_wdata,
  output logic cfg_wr,
  output logic cfg_rd,
  input wire logic [7:0] cfg_rdata,
  input wire logic cfg_rvalid
);
  // Idle port with strobes low
  initial begin
    cfg_addr = 8'h00;
    cfg_wdata = 8'h00;
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
  end
  // Data is inverted once released so a stale byte never passes for a good one
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    cfg_addr <= a;
    cfg_wdata <= d;
    cfg_wr <= 1'b1;
    @(posedge clk);
    cfg_wr <= 1'b0;
    cfg_wdata <= ~d;
  endtask
  // Missing answer returns unknown, which no expectation matches
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int n;
    @(posedge clk);
    cfg_addr <= a;
    cfg_rd <= 1'b1;
    @(posedge clk);
    cfg_rd <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (cfg_rvalid !== 1'b1 && n < 4);
    d = (cfg_rvalid === 1'b1) ? cfg_rdata : 8'hxx;
  endtask
  // Peripheral draw folded in; self-powered figures capped at 50 units
  function automatic logic [7:0] budget(input logic [7:0] hub, input logic [7:0] extra,
                                        input logic self_mode);
    budget = hub + extra;
    if (self_mode && budget > hpdc_pkg::SELF_LIMIT_UNITS) budget = hpdc_pkg::SELF_LIMIT_UNITS;
  endfunction
  // Characters go low byte first; callers keep the length within 31
  task automatic put_char(input logic [4:0] i, input logic [15:0] c);
    wr(hpdc_pkg::OFS_MAKER_STR_FIRST + {2'h0, i, 1'h0}, c[7:0]);
    wr(hpdc_pkg::OFS_MAKER_STR_FIRST + {2'h0, i, 1'h1}, c[15:8]);
  endtask
endmodule // hpdc_cfg_host
`default_nettype wire

/* File: tb_hpdc_config.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_hpdc_config;
  localparam int STEP = 2;
  logic clk, rstn, ce, cfg_wr, cfg_rd, cfg_rvalid, pin, start, good, rsp, lim;
  logic [7:0] addr, wdata, rdata, rmp, rcc, rlen, d;
  logic [8:0] rmp_ma, rcc_ma;
  logic [15:0] lang, sch;
  logic [4:0] idx;
  logic [7:0] shadow [8];
  int mismatches = 0, n_compared = 0, cyc = 0, n;
  hpdc_config #(.SETTLE_STEP_CYCLES(STEP)) i_dut (.clk, .rstn, .ce, .cfg_addr(addr),
    .cfg_wdata(wdata), .cfg_wr, .cfg_rd, .cfg_rdata(rdata), .cfg_rvalid,
    .self_powered_pin(pin), .port_power_start(start), .port_power_good(good),
    .rpt_max_power(rmp), .rpt_ctrl_current(rcc), .rpt_max_power_ma(rmp_ma),
    .rpt_ctrl_current_ma(rcc_ma), .rpt_self_powered(rsp), .rpt_language_id(lang),
    .rpt_maker_len(rlen), .str_char_idx(idx), .str_char(sch), .self_limit_exceeded(lim));
  hpdc_cfg_host host (.clk, .cfg_addr(addr), .cfg_wdata(wdata), .cfg_wr, .cfg_rd,
    .cfg_rdata(rdata), .cfg_rvalid);
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict;
    if (mismatches == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Hang guard well above the roughly 300 cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      give_verdict();
    end
  end
  initial begin
    rstn = 1'b0;
    ce = 1'b1;
    pin = 1'b0;
    start = 1'b0;
    idx = 5'h00;
    void'($urandom(68));
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    // Reset values: both controller currents at 50 units, the rest cleared
    for (int a = 12; a < 20; a++) begin
      host.rd(8'(a), d);
      check("reset value", d, (a == 14 || a == 15) ? 16'h0032 : 16'h0000);
    end
    check("bus current mA", rcc_ma, 16'h0064);
    // Every register round trip; length written one above the limit
    for (int a = 12; a < 20; a++) begin
      shadow[a-12] = (a == 19) ? 8'h20 : 8'($urandom);
      if (a < 14)
        shadow[a-12] = host.budget(8'($urandom_range(40)), 8'($urandom_range(40)), a == 12);
      if (a == 14)
        shadow[a-12] = 8'($urandom_range(50));
      host.wr(8'(a), shadow[a-12]);
      host.rd(8'(a), d);
      check("readback", d, (a == 19) ? 16'h001f : shadow[a-12]);
    end
    host.rd(8'h05, d);
    check("unmapped low", d, 16'h0000);
    host.rd(8'hd0, d);
    check("unmapped high", d, 16'h0000);
    // Reports follow the synchronised mode pin
    for (int m = 0; m < 2; m++) begin
      pin <= m[0];
      repeat (5) @(posedge clk);
      check("mode", rsp, m[0]);
      check("max power", rmp, shadow[1-m]);
      check("current", rcc, shadow[3-m]);
      check("power mA", rmp_ma, {shadow[1-m], 1'h0});
      check("current mA", rcc_ma, {shadow[3-m], 1'h0});
    end
    check("limit flag", lim, shadow[0] > 8'h32 || shadow[2] > 8'h32);
    check("language", lang, {shadow[5], shadow[6]});
    // Longest string; index 31 lies past it and reads zero
    host.wr(hpdc_pkg::OFS_MAKER_LEN, 8'h1f);
    for (int i = 0; i < 31; i++) host.put_char(5'(i), 16'(i * 16'h0102 + 16'h4130));
    for (int i = 0; i < 32; i++) begin
      idx <= 5'(i);
      repeat (2) @(posedge clk);
      check("char", sch, (i < 31) ? 16'(i * 16'h0102 + 16'h4130) : 16'h0000);
    end
    check("maker length", rlen, 16'h001f);
    // Good is registered steps times STEP edges after the start edge, seen one edge on
    for (int s = 0; s < 4; s += 3) begin
      host.wr(hpdc_pkg::OFS_SETTLE_TIME, 8'(s));
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (good !== 1'b1 && n < 50);
      check("settle edges", 16'(n), 16'(s * STEP + 1));
    end
    give_verdict();
  end
endmodule // tb_hpdc_config
bind hpdc_config hpdc_config_sva i_sva (.clk, .rstn, .ce, .cfg_addr, .cfg_wdata, .cfg_wr,
  .cfg_rd, .cfg_rvalid, .self_powered_pin, .port_power_start, .port_power_good,
  .rpt_max_power, .rpt_ctrl_current, .rpt_max_power_ma, .rpt_ctrl_current_ma,
  .rpt_self_powered, .rpt_language_id, .rpt_maker_len);
`default_nettype wire
